// >>> rtl/smsp_consts.vh
// constants for the byte-wide serial port
`ifndef SMSP_CONSTS_VH
`define SMSP_CONSTS_VH
`define SMSP_DATA_W       8
`define SMSP_FIFO_DEPTH   16
`define SMSP_FIFO_AW      4
`define SMSP_CNT_W        7
`define SMSP_BITS         4'h8
`define SMSP_DATA_RST     8'h00
`define SMSP_RATE_DIV4    3'h4
`define SMSP_RATE_DIV8    3'h0
`define SMSP_RATE_DIV16   3'h1
`define SMSP_RATE_DIV32   3'h6
`define SMSP_RATE_DIV64   3'h2
`define SMSP_RATE_DIV128  3'h3
`define SMSP_HALF_DIV4    7'h01
`define SMSP_HALF_DIV8    7'h03
`define SMSP_HALF_DIV16   7'h07
`define SMSP_HALF_DIV32   7'h0f
`define SMSP_HALF_DIV64   7'h1f
`define SMSP_HALF_DIV128  7'h3f
`endif

// >>> rtl/smsp_fifo.v
// parameterised valid/ready fifo
`timescale 1ns/1ps
module smsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ff;
  reg [AW:0]      rd_ff;
  wire            full;
  wire            empty;
  assign full      = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty     = (wr_ff == rd_ff);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ff[AW-1:0]];
  always @(posedge clk_sys) begin
    if (ce && in_valid && !full) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (in_valid && !full) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule // smsp_fifo

// >>> rtl/smsp_port.v
// byte-wide serial port, master or slave
`timescale 1ns/1ps
`include "smsp_consts.vh"
module smsp_port (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       ce,
  input  wire       halt_mode,
  input  wire       cpu_irq_mask,
  input  wire       ctrl_wr,
  input  wire       port_interrupt_enable,
  input  wire       port_enable,
  input  wire       master_select,
  input  wire       clock_polarity,
  input  wire       clock_phase,
  input  wire [2:0] rate_select,
  input  wire       status_rd,
  input  wire       status_wr,
  input  wire       sw_select_management,
  input  wire       sw_select_level,
  input  wire       data_wr,
  input  wire [7:0] data_wdata,
  output reg        data_wr_ready,
  input  wire       data_rd,
  output reg  [7:0] data_rdata,
  output reg        rx_valid,
  output reg        transfer_complete_flag,
  output reg        write_collision_flag,
  output reg        overrun_flag,
  output reg        mode_fault_flag,
  output reg        port_enable_ff,
  output reg        master_select_ff,
  output reg        irq_req,
  output reg        busy,
  input  wire       sck_in,
  output reg        sck_out,
  output reg        sck_oe,
  input  wire       mosi_in,
  output reg        mosi_out,
  output reg        mosi_oe,
  input  wire       miso_in,
  output reg        miso_out,
  output reg        miso_oe,
  input  wire       ss_n_in
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [6:0] half_period;
    input [2:0] rs;
    begin
      case (rs)
        `SMSP_RATE_DIV4:   half_period = `SMSP_HALF_DIV4;
        `SMSP_RATE_DIV8:   half_period = `SMSP_HALF_DIV8;
        `SMSP_RATE_DIV16:  half_period = `SMSP_HALF_DIV16;
        `SMSP_RATE_DIV32:  half_period = `SMSP_HALF_DIV32;
        `SMSP_RATE_DIV64:  half_period = `SMSP_HALF_DIV64;
        `SMSP_RATE_DIV128: half_period = `SMSP_HALF_DIV128;
        default:           half_period = `SMSP_HALF_DIV8;
      endcase
    end
  endfunction

  localparam ST_IDLE = 2'b00;
  localparam ST_LEAD = 2'b01;
  localparam ST_TRAIL = 2'b10;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [1:0] sck_s1_ff, sck_s2_ff;
  reg       sck_d_ff;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_s1_ff <= 2'b00;
      sck_s2_ff <= 2'b00;
      sck_d_ff  <= 1'b0;
    end else if (ce) begin
      sck_s1_ff <= {sck_in, mosi_in};
      sck_s2_ff <= sck_s1_ff;
      sck_d_ff  <= sck_s2_ff[1];
    end
  end
  reg [1:0] pin_s1_ff, pin_s2_ff;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= 2'b11;
      pin_s2_ff <= 2'b11;
    end else if (ce) begin
      pin_s1_ff <= {ss_n_in, miso_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire sck_s  = sck_s2_ff[1];
  wire mosi_s = sck_s2_ff[0];
  wire ss_s   = pin_s2_ff[1];
  wire miso_s = pin_s2_ff[0];
  wire ss_int = sw_select_management ? sw_select_level : ss_s;
  // clock edges normalised to polarity: lead leaves idle, trail returns
  wire sck_rise = sck_s & ~sck_d_ff;
  wire sck_fall = ~sck_s & sck_d_ff;
  wire s_lead   = clock_polarity ? sck_fall : sck_rise;
  wire s_trail  = clock_polarity ? sck_rise : sck_fall;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wire       run = ce & ~halt_mode;
  reg  [1:0] st_ff;
  reg  [6:0] cnt_ff;
  reg  [3:0] bits_ff;
  reg  [7:0] shift_ff;
  reg        slave_armed_ff;
  reg        csr_seen_ff;
  reg        csr_mode_fault_flag_seen_ff;
  wire       done_byte;
  wire [7:0] rx_byte;

  // receive buffer sits behind a fifo; a full fifo stalls the shifter
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg        fifo_push;
  reg  [7:0] fifo_push_data;
  smsp_fifo #(
    .WIDTH (`SMSP_DATA_W),
    .DEPTH (`SMSP_FIFO_DEPTH),
    .AW    (`SMSP_FIFO_AW)
  ) u_rxq (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (run),
    .in_data   (fifo_push_data),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (data_rd)
  );

  wire master = master_select_ff & port_enable_ff;
  wire slave_on = port_enable_ff & ~master_select_ff & ~ss_int;
  wire active = (st_ff != ST_IDLE);
  wire wr_ok  = data_wr & ~(transfer_complete_flag & ~csr_seen_ff);
  wire tick   = (cnt_ff == 7'h00);

  // ---------------------------------------------------------------
  // shifter and clock generator
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 7'h00;
      bits_ff <= 4'h0;
      shift_ff <= `SMSP_DATA_RST;
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      slave_armed_ff <= 1'b0;
    end else if (run) begin
      if (!active) begin
        sck_out <= clock_polarity;
      end
      if (!port_enable_ff) begin
        st_ff <= ST_IDLE;
        slave_armed_ff <= 1'b0;
      end else if (!active && wr_ok && fifo_in_ready) begin
        shift_ff <= data_wdata;
        bits_ff <= `SMSP_BITS;
        cnt_ff <= half_period(rate_select);
        if (master) begin
          st_ff <= ST_LEAD;
          if (!clock_phase) mosi_out <= data_wdata[7];
        end else begin
          slave_armed_ff <= 1'b1;
          if (!clock_phase) miso_out <= data_wdata[7];
        end
      end else if (master && active && fifo_in_ready) begin
        cnt_ff <= tick ? half_period(rate_select) : cnt_ff - 7'h01;
        if (tick) begin
          sck_out <= ~sck_out;
          if (st_ff == ST_LEAD) begin
            st_ff <= ST_TRAIL;
            if (clock_phase) mosi_out <= shift_ff[7];
            else shift_ff <= {shift_ff[6:0], miso_s};
          end else begin
            bits_ff <= bits_ff - 4'h1;
            if (clock_phase) shift_ff <= {shift_ff[6:0], miso_s};
            st_ff <= (bits_ff == 4'h1) ? ST_IDLE : ST_LEAD;
            if (!clock_phase && bits_ff != 4'h1) mosi_out <= shift_ff[7];
          end
        end
      end else if (!master_select_ff && slave_on && fifo_in_ready) begin
        // slave runs on sampled master clock
        if (!active && (s_lead || s_trail)) begin
          if (!slave_armed_ff) bits_ff <= `SMSP_BITS;
          slave_armed_ff <= 1'b0;
          st_ff <= ST_LEAD;
        end
        if (s_lead) begin
          if (clock_phase) miso_out <= shift_ff[7];
          else shift_ff <= {shift_ff[6:0], mosi_s};
          if (!active && !slave_armed_ff) bits_ff <= `SMSP_BITS;
        end
        if (s_trail && active) begin
          if (clock_phase) shift_ff <= {shift_ff[6:0], mosi_s};
          else miso_out <= shift_ff[7];
          bits_ff <= bits_ff - 4'h1;
          if (bits_ff == 4'h1) st_ff <= ST_IDLE;
        end
      end else if (!slave_on && !master) begin
        st_ff <= ST_IDLE;
      end
    end
  end
  assign done_byte = active && !fifo_in_ready ? 1'b0 :
                     (active && bits_ff == 4'h1 &&
                      (master ? (tick && st_ff == ST_TRAIL) : s_trail));
  // phase 0 captures on the lead edge, so the byte is complete at the last trail
  assign rx_byte = (clock_phase == 1'b0) ? shift_ff :
                   {shift_ff[6:0], master ? miso_s : mosi_s};

  // ---------------------------------------------------------------
  // flags, control and pin enables
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transfer_complete_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      overrun_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
      port_enable_ff <= 1'b0;
      master_select_ff <= 1'b0;
      csr_seen_ff <= 1'b0;
      csr_mode_fault_flag_seen_ff <= 1'b0;
      irq_req <= 1'b0;
      busy <= 1'b0;
      rx_valid <= 1'b0;
      data_rdata <= `SMSP_DATA_RST;
      fifo_push <= 1'b0;
      fifo_push_data <= `SMSP_DATA_RST;
      sck_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      data_wr_ready <= 1'b0;
    end else if (run) begin
      fifo_push <= 1'b0;
      busy <= active;
      rx_valid <= fifo_out_valid;
      data_rdata <= fifo_out_data;
      if (status_rd || status_wr) begin
        csr_seen_ff <= transfer_complete_flag;
      end
      if (status_rd) begin
        csr_mode_fault_flag_seen_ff <= mode_fault_flag;
        overrun_flag <= 1'b0;
        write_collision_flag <= 1'b0;
      end
      if (csr_seen_ff && (data_rd || (!master_select_ff && data_wr))) begin
        transfer_complete_flag <= 1'b0;
        csr_seen_ff <= 1'b0;
      end
      if (data_wr && active) begin
        write_collision_flag <= 1'b1;
      end
      if (done_byte) begin
        transfer_complete_flag <= 1'b1;
        if (transfer_complete_flag && !(csr_seen_ff && data_rd)) begin
          overrun_flag <= 1'b1;
        end else begin
          fifo_push <= 1'b1;
          fifo_push_data <= rx_byte;
        end
      end
      if (ctrl_wr) begin
        if (!mode_fault_flag || csr_mode_fault_flag_seen_ff) begin
          port_enable_ff <= port_enable & ss_int | port_enable & ~master_select;
          master_select_ff <= master_select & ss_int;
          mode_fault_flag <= 1'b0;
          csr_mode_fault_flag_seen_ff <= 1'b0;
        end else begin
          port_enable_ff <= 1'b0;
          master_select_ff <= 1'b0;
        end
      end
      if (master_select_ff && !ss_int) begin
        mode_fault_flag <= 1'b1;
        port_enable_ff <= 1'b0;
        master_select_ff <= 1'b0;
      end
      irq_req <= port_interrupt_enable & ~cpu_irq_mask &
                 (transfer_complete_flag | mode_fault_flag | overrun_flag);
      sck_oe <= master;
      mosi_oe <= master;
      miso_oe <= slave_on;
      data_wr_ready <= fifo_in_ready;
    end
  end
endmodule // smsp_port

// >>> tb/smsp_port_assertions.sv
// concurrent checks on the serial port flags and pins
`timescale 1ns/1ps
module smsp_port_checker (
  input wire       clk_sys,
  input wire       rst,
  input wire       ce,
  input wire       halt_mode,
  input wire       ctrl_wr,
  input wire       status_rd,
  input wire       data_wr,
  input wire [7:0] data_wdata,
  input wire       data_rd,
  input wire       sw_select_management,
  input wire       clock_phase,
  input wire       ss_n_in,
  input wire       transfer_complete_flag,
  input wire       write_collision_flag,
  input wire       overrun_flag,
  input wire       mode_fault_flag,
  input wire       port_enable_ff,
  input wire       master_select_ff,
  input wire       irq_req,
  input wire       busy,
  input wire       mosi_out
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire run = ce && !halt_mode;
  irq_has_cause_a: assert property (
    irq_req |-> (transfer_complete_flag || overrun_flag || mode_fault_flag ||
    $past(transfer_complete_flag || overrun_flag || mode_fault_flag)))
    else $error("interrupt without event flag");
  msb_first_out_a: assert property (
    data_wr && run && !busy && !transfer_complete_flag && port_enable_ff && master_select_ff &&
    !clock_phase |=> mosi_out == $past(data_wdata[7]) ##1 busy)
    else $error("byte start not msb first");
  collision_flag_a: assert property (
    data_wr && run && busy |=> write_collision_flag)
    else $error("write during transfer not flagged");
  fault_on_select_a: assert property (
    (run && master_select_ff && !sw_select_management && !ss_n_in) [*3]
    |-> ##[0:2] mode_fault_flag)
    else $error("select low in master mode not faulted");
  fault_drops_mode_a: assert property (
    $rose(mode_fault_flag) |-> ##[0:1] !port_enable_ff && !master_select_ff)
    else $error("fault left port enabled");
  tcf_clear_cause_a: assert property (
    $fell(transfer_complete_flag) |-> $past(data_rd || data_wr))
    else $error("transfer flag cleared without data access");
  ovr_clear_cause_a: assert property (
    $fell(overrun_flag) |-> $past(status_rd))
    else $error("overrun cleared without status read");
  fault_clear_cause_a: assert property (
    $fell(mode_fault_flag) |-> $past(ctrl_wr))
    else $error("fault cleared without control write");
  ovr_needs_flag_a: assert property (
    $rose(overrun_flag) |-> transfer_complete_flag)
    else $error("overrun without pending byte");
endmodule // smsp_port_checker

bind smsp_port smsp_port_checker smsp_port_checker_i (.*);

// >>> tb/smsp_far_slave.sv
// behavioural far-side slave, clock mode 0, echoes the last byte
`timescale 1ns/1ps
module smsp_far_slave (
  input  wire       sck,
  input  wire       mosi,
  input  wire       sel_n,
  output reg        miso,
  output reg  [7:0] rx_byte
);
  reg [7:0] shift_ff;
  reg [7:0] tx_ff;
  reg [2:0] bit_ff;
  initial begin
    shift_ff = 8'h00;
    tx_ff = 8'hA5;
    bit_ff = 3'h0;
    rx_byte = 8'h00;
    miso = 1'h0;
  end
  // ----------
  // shifting
  // ----------
  // a released line shows the opposite of its last level
  always @(posedge sel_n) miso = ~miso;
  always @(negedge sel_n) miso = tx_ff[7];
  always @(posedge sck) if (!sel_n) begin
    shift_ff = {shift_ff[6:0], mosi};
    bit_ff = bit_ff + 3'h1;
    if (bit_ff == 3'h0) rx_byte = shift_ff;
  end
  always @(negedge sck) if (!sel_n) begin
    if (bit_ff == 3'h0) tx_ff = rx_byte;
    miso = tx_ff[3'h7 - bit_ff];
  end
endmodule // smsp_far_slave

// >>> tb/tb_smsp_port.sv
// testbench for the byte-wide serial port in master and slave mode
`timescale 1ns/1ps
`include "smsp_consts.vh"
module tb_smsp_port;
  logic       clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, halt_mode = 1'h0, cpu_irq_mask = 1'h0;
  logic       ctrl_wr = 1'h0, port_interrupt_enable = 1'h1, port_enable = 1'h0;
  logic       master_select = 1'h0, clock_polarity = 1'h0, clock_phase = 1'h0;
  logic       status_rd = 1'h0, status_wr = 1'h0, data_wr = 1'h0, data_rd = 1'h0;
  logic       sw_select_management = 1'h0, sw_select_level = 1'h1, ss_n_in = 1'h1, sel_n = 1'h1;
  logic [2:0] rate_select = `SMSP_RATE_DIV16;
  logic [7:0] data_wdata = 8'h00, data_rdata, far_rx, sgot;
  logic       far_sck = 1'h0, far_mosi = 1'h0;
  logic       data_wr_ready, rx_valid, transfer_complete_flag, write_collision_flag;
  logic       overrun_flag, mode_fault_flag, port_enable_ff, master_select_ff, irq_req, busy;
  logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, far_miso;
  wire        sck_in = sck_oe ? sck_out : far_sck;
  wire        mosi_in = mosi_oe ? mosi_out : far_mosi;
  wire        miso_in = miso_oe ? miso_out : far_miso;
  int         mismatches = 0, cmp_count = 0;
  smsp_port smsp_port_i (.*);
  smsp_far_slave smsp_far_slave_i (.sck(sck_in), .mosi(mosi_in), .sel_n(sel_n),
    .miso(far_miso), .rx_byte(far_rx));
  // ----------
  // helpers
  // ----------
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic ctl(input logic en, input logic ms);
    @(negedge clk_sys);
    {ctrl_wr, port_enable, master_select} = {1'h1, en, ms};
    @(negedge clk_sys);
    ctrl_wr = 1'h0;
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge clk_sys);
    data_wr = 1'h1;
    data_wdata = d;
    @(negedge clk_sys);
    data_wr = 1'h0;
  endtask
  task automatic srd;
    @(negedge clk_sys);
    status_rd = 1'h1;
    @(negedge clk_sys);
    status_rd = 1'h0;
  endtask
  task automatic finish_byte;
    int i;
    tick(2);
    for (i = 0; i < 400 && busy !== 1'h0; i++) @(negedge clk_sys);
    sel_n = 1'h1;
    tick(1);
    sel_n = 1'h0;
    tick(1);
  endtask
  // bench acts as the far master for slave mode, any polarity and phase
  task automatic mxfer(input logic [7:0] d);
    int i;
    sgot = 8'h00;
    ss_n_in = 1'h0;
    tick(8);
    for (i = 7; i >= 0; i--) begin
      if (!clock_phase) far_mosi = d[i];
      tick(8);
      if (!clock_phase) sgot = {sgot[6:0], miso_in};
      far_sck = ~far_sck;
      if (clock_phase) far_mosi = d[i];
      tick(8);
      if (clock_phase) sgot = {sgot[6:0], miso_in};
      far_sck = ~far_sck;
    end
    tick(8);
    ss_n_in = 1'h1;
    tick(4);
  endtask
  task automatic drd(input logic [7:0] e);
    int i;
    for (i = 0; i < 20 && rx_valid !== 1'h1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    chk(data_rdata, e);
    data_rd = 1'h1;
    @(negedge clk_sys);
    data_rd = 1'h0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'h0;
    tick(4);
    sel_n = 1'h0;
    chk({busy, irq_req, port_enable_ff, transfer_complete_flag}, 8'h00);
    status_wr = 1'h1;
    tick(1);
    status_wr = 1'h0;
    ctl(1'h1, 1'h1);
    tick(2);
    chk({port_enable_ff, master_select_ff}, 8'h03);
    chk({data_wr_ready, sck_oe, mosi_oe, miso_oe}, 8'h0E);
    wr(8'h3C);
    finish_byte();
    chk(far_rx, 8'h3C);
    chk(irq_req, 8'h01);
    cpu_irq_mask = 1'h1;
    tick(2);
    chk(irq_req, 8'h00);
    cpu_irq_mask = 1'h0;
    srd();
    drd(8'hA5);
    tick(1);
    chk(transfer_complete_flag, 8'h00);
    $display("test single byte done");
    wr(8'h55);
    wr(8'h77);
    tick(1);
    chk(write_collision_flag, 8'h01);
    finish_byte();
    chk(far_rx, 8'h55);
    wr(8'h11);
    tick(2);
    chk(busy, 8'h00);
    srd();
    drd(8'h3C);
    tick(1);
    chk({write_collision_flag, transfer_complete_flag}, 8'h00);
    $display("test collision done");
    wr(8'h21);
    finish_byte();
    srd();
    wr(8'h42);
    finish_byte();
    chk({overrun_flag, irq_req}, 8'h03);
    chk(far_rx, 8'h42);
    srd();
    tick(1);
    chk(overrun_flag, 8'h00);
    drd(8'h55);
    tick(1);
    chk(transfer_complete_flag, 8'h00);
    $display("test overrun done");
    ss_n_in = 1'h0;
    tick(6);
    chk({mode_fault_flag, port_enable_ff, master_select_ff, sck_oe, mosi_oe}, 8'h10);
    ss_n_in = 1'h1;
    tick(4);
    ctl(1'h1, 1'h1);
    tick(2);
    chk({mode_fault_flag, port_enable_ff, master_select_ff}, 8'h04);
    srd();
    ctl(1'h1, 1'h1);
    tick(2);
    chk({mode_fault_flag, port_enable_ff, master_select_ff}, 8'h03);
    halt_mode = 1'h1;
    ctl(1'h0, 1'h0);
    chk({port_enable_ff, master_select_ff}, 8'h03);
    halt_mode = 1'h0;
    $display("test mode fault done");
    sel_n = 1'h1;
    ctl(1'h0, 1'h0);
    ctl(1'h1, 1'h0);
    wr(8'hC3);
    mxfer(8'h96);
    chk(sgot, 8'hC3);
    chk(transfer_complete_flag, 8'h01);
    srd();
    wr(8'h5A);
    tick(1);
    chk(transfer_complete_flag, 8'h00);
    drd(8'h96);
    $display("test slave mode 0 done");
    ctl(1'h0, 1'h0);
    {clock_polarity, clock_phase} = 2'h3;
    far_sck = 1'h1;
    tick(4);
    ctl(1'h1, 1'h0);
    mxfer(8'h69);
    chk(sgot, 8'h5A);
    srd();
    drd(8'h69);
    tick(1);
    chk(transfer_complete_flag, 8'h00);
    $display("test slave mode 3 done");
    tally_and_finish();
  end
endmodule // tb_smsp_port
